// File: logic/pig_pkg.sv
`default_nettype none
package pig_pkg;

  localparam int ADDR_W_DEF = 12;
  localparam int DATA_W     = 32;
  localparam int STRB_W     = DATA_W / 8;
  localparam int NUM_SRC    = 3;

  // register byte offsets
  localparam logic [31:0] OFF_ENABLE = 32'h0000_0014;
  localparam logic [31:0] OFF_RAW    = 32'h0000_0018;
  localparam logic [31:0] OFF_ISC    = 32'h0000_001C;

  // source order inside the source vectors
  localparam int SRC_GEN0  = 0;
  localparam int SRC_GEN1  = 1;
  localparam int SRC_FAULT = 2;

  // bit position of each source in every register
  localparam logic [NUM_SRC-1:0][4:0] SRC_POS = {5'h10, 5'h01, 5'h00};
  // only the fault source is held at this level
  localparam logic [NUM_SRC-1:0]      SRC_LATCH = 3'h4;

  localparam logic [NUM_SRC-1:0] EN_RESET  = 3'h0;
  localparam logic [NUM_SRC-1:0] RAW_RESET = 3'h0;
  localparam logic [DATA_W-1:0]  RDATA_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    PIG_WR_IDLE = 1'b0,
    PIG_WR_RESP = 1'b1
  } pig_wr_st_t;

  typedef enum logic [0:0] {
    PIG_RD_IDLE = 1'b0,
    PIG_RD_DATA = 1'b1
  } pig_rd_st_t;

endpackage : pig_pkg
`default_nettype wire

// File: logic/pig_src_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pig_src_cell #(
  parameter bit LATCH = 1'b0
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic src_in,
  input  wire logic clr_in,
  output var  logic raw_out
);
  import pig_pkg::*;

  typedef struct packed {
    logic raw;
  } pig_cell_st_t;

  pig_cell_st_t cell_reg;
  pig_cell_st_t cell_next;

  always_comb begin
    cell_next = cell_reg;
    if (LATCH) begin
      // set wins over a clear in the same cycle
      cell_next.raw = src_in | (cell_reg.raw & ~clr_in);
    end else begin
      cell_next.raw = src_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cell_reg.raw <= RAW_RESET[0];
    end else begin
      cell_reg <= cell_next;
    end
  end

  assign raw_out = cell_reg.raw;

endmodule : pig_src_cell
`default_nettype wire

// File: logic/pig_chan_hold.sv
`timescale 1ns/1ps
`default_nettype none
module pig_chan_hold #(
  parameter int W = 32
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         valid_in,
  input  wire logic [W-1:0] data_in,
  input  wire logic         take_in,
  output var  logic         ready_out,
  output var  logic         full_out,
  output var  logic [W-1:0] data_out
);
  import pig_pkg::*;

  typedef struct packed {
    logic         full;
    logic         ready;
    logic [W-1:0] data;
  } pig_hold_st_t;

  pig_hold_st_t hold_reg;
  pig_hold_st_t hold_next;

  always_comb begin
    hold_next = hold_reg;
    if (take_in) begin
      hold_next.full = 1'b0;
    end
    if (hold_reg.ready && valid_in) begin
      hold_next.full = 1'b1;
      hold_next.data = data_in;
    end
    // ready is registered, so a held beat blocks the next one
    hold_next.ready = ~hold_next.full;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign ready_out = hold_reg.ready;
  assign full_out  = hold_reg.full;
  assign data_out  = hold_reg.data;

endmodule : pig_chan_hold
`default_nettype wire

// File: logic/pig_top.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pig_top #(
  parameter int ADDR_W = pig_pkg::ADDR_W_DEF
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       s_axi_awvalid_in,
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr_in,
  output var  logic                       s_axi_awready_out,
  input  wire logic                       s_axi_wvalid_in,
  input  wire logic [pig_pkg::DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [pig_pkg::STRB_W-1:0] s_axi_wstrb_in,
  output var  logic                       s_axi_wready_out,
  output var  logic                       s_axi_bvalid_out,
  output var  logic [1:0]                 s_axi_bresp_out,
  input  wire logic                       s_axi_bready_in,
  input  wire logic                       s_axi_arvalid_in,
  input  wire logic [ADDR_W-1:0]          s_axi_araddr_in,
  output var  logic                       s_axi_arready_out,
  output var  logic                       s_axi_rvalid_out,
  output var  logic [pig_pkg::DATA_W-1:0] s_axi_rdata_out,
  output var  logic [1:0]                 s_axi_rresp_out,
  input  wire logic                       s_axi_rready_in,
  input  wire logic                       fault_in,
  input  wire logic                       gen0_irq_in,
  input  wire logic                       gen1_irq_in,
  input  wire logic                       fault_clr_in,
  output var  logic                       intr_out
);
  import pig_pkg::*;

  typedef struct packed {
    pig_wr_st_t        wr_st;
    logic [1:0]        bresp;
    pig_rd_st_t        rd_st;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [NUM_SRC-1:0] en;
    logic              irq;
  } pig_top_st_t;

  pig_top_st_t top_reg;
  pig_top_st_t top_next;

  logic                aw_full;
  logic [ADDR_W-1:0]   aw_addr;
  logic                w_full;
  logic [DATA_W+STRB_W-1:0] w_beat;
  logic                wr_take;
  logic [NUM_SRC-1:0]  src_level;
  logic [NUM_SRC-1:0]  src_clr;
  logic [NUM_SRC-1:0]  isc_clr;
  logic [NUM_SRC-1:0]  raw;

  function automatic logic [DATA_W-1:0] spread(
    input logic [NUM_SRC-1:0] v
  );
    logic [DATA_W-1:0] o;
    o = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      o[SRC_POS[i]] = v[i];
    end
    // reserved positions read as zero
    return o;
  endfunction : spread

  function automatic logic [NUM_SRC-1:0] gather(
    input logic [DATA_W-1:0] v
  );
    logic [NUM_SRC-1:0] o;
    o = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      o[i] = v[SRC_POS[i]];
    end
    return o;
  endfunction : gather

  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [STRB_W-1:0] s
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < STRB_W; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [31:0]       off
  );
    // low two address bits are ignored: word access only
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction : hit

  pig_chan_hold #(
    .W (ADDR_W)
  ) u_aw_hold (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .valid_in    (s_axi_awvalid_in),
    .data_in     (s_axi_awaddr_in),
    .take_in     (wr_take),
    .ready_out   (s_axi_awready_out),
    .full_out    (aw_full),
    .data_out    (aw_addr)
  );

  pig_chan_hold #(
    .W (DATA_W + STRB_W)
  ) u_w_hold (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .valid_in    (s_axi_wvalid_in),
    .data_in     ({s_axi_wstrb_in, s_axi_wdata_in}),
    .take_in     (wr_take),
    .ready_out   (s_axi_wready_out),
    .full_out    (w_full),
    .data_out    (w_beat)
  );

  // source vector: nothing else feeds the module interrupt
  assign src_level[SRC_GEN0]  = gen0_irq_in;
  assign src_level[SRC_GEN1]  = gen1_irq_in;
  assign src_level[SRC_FAULT] = fault_in;

  // write is done once both halves are held and no response waits
  assign wr_take = aw_full & w_full & (top_reg.wr_st == PIG_WR_IDLE);

  always_comb begin
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] wdata;
    wmask   = lane_mask(w_beat[DATA_W +: STRB_W]);
    wdata   = w_beat[DATA_W-1:0];
    isc_clr = '0;
    if (wr_take && hit(aw_addr, OFF_ISC)) begin
      // zeros and non-latched positions are ignored
      isc_clr = gather(wdata & wmask) & SRC_LATCH;
    end
  end

  assign src_clr = isc_clr | ({NUM_SRC{fault_clr_in}} & SRC_LATCH);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      pig_src_cell #(
        .LATCH (SRC_LATCH[gi])
      ) u_cell (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .src_in      (src_level[gi]),
        .clr_in      (src_clr[gi]),
        .raw_out     (raw[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] wdata;
    logic [NUM_SRC-1:0] en_mask;
    wmask    = lane_mask(w_beat[DATA_W +: STRB_W]);
    wdata    = w_beat[DATA_W-1:0];
    en_mask  = gather(wmask);
    top_next = top_reg;

    // write channel
    if (wr_take) begin
      top_next.wr_st = PIG_WR_RESP;
      top_next.bresp = RESP_OKAY;
      if (hit(aw_addr, OFF_ENABLE)) begin
        // only enabled lanes change; reserved bits are not stored
        top_next.en = (gather(wdata) & en_mask) |
                      (top_reg.en & ~en_mask);
      end else if (hit(aw_addr, OFF_RAW) || hit(aw_addr, OFF_ISC)) begin
        // raw is read-only; the isc clear goes to the cells
        top_next.bresp = RESP_OKAY;
      end else begin
        top_next.bresp = RESP_SLVERR;
      end
    end else if (top_reg.wr_st == PIG_WR_RESP && s_axi_bready_in) begin
      top_next.wr_st = PIG_WR_IDLE;
    end

    // read channel
    case (top_reg.rd_st)
      PIG_RD_IDLE: begin
        top_next.arready = 1'b1;
        if (top_reg.arready && s_axi_arvalid_in) begin
          top_next.rd_st   = PIG_RD_DATA;
          top_next.arready = 1'b0;
          top_next.rresp   = RESP_OKAY;
          if (hit(s_axi_araddr_in, OFF_ENABLE)) begin
            top_next.rdata = spread(top_reg.en);
          end else if (hit(s_axi_araddr_in, OFF_RAW)) begin
            top_next.rdata = spread(raw);
          end else if (hit(s_axi_araddr_in, OFF_ISC)) begin
            top_next.rdata = spread(raw & top_reg.en);
          end else begin
            top_next.rdata = RDATA_RESET;
            top_next.rresp = RESP_SLVERR;
          end
        end
      end
      PIG_RD_DATA: begin
        top_next.arready = 1'b0;
        if (s_axi_rready_in) begin
          top_next.rd_st = PIG_RD_IDLE;
        end
      end
      default: begin
        top_next.rd_st   = PIG_RD_IDLE;
        top_next.arready = 1'b0;
      end
    endcase

    // each source gated by its own enable, then ORed
    top_next.irq = |(raw & top_reg.en);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      top_reg.wr_st   <= PIG_WR_IDLE;
      top_reg.bresp   <= RESP_OKAY;
      top_reg.rd_st   <= PIG_RD_IDLE;
      top_reg.arready <= 1'b0;
      top_reg.rdata   <= RDATA_RESET;
      top_reg.rresp   <= RESP_OKAY;
      top_reg.en      <= EN_RESET;
      top_reg.irq     <= 1'b0;
    end else begin
      top_reg <= top_next;
    end
  end

  assign s_axi_bvalid_out  = (top_reg.wr_st == PIG_WR_RESP);
  assign s_axi_bresp_out   = top_reg.bresp;
  assign s_axi_arready_out = top_reg.arready;
  assign s_axi_rvalid_out  = (top_reg.rd_st == PIG_RD_DATA);
  assign s_axi_rdata_out   = top_reg.rdata;
  assign s_axi_rresp_out   = top_reg.rresp;
  assign intr_out          = top_reg.irq;

endmodule : pig_top
`default_nettype wire

// File: test/pig_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pig_checker
  import pig_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic              core_clk_in,
  input wire logic              rst_n_in,
  input wire logic              s_axi_awvalid_in,
  input wire logic              s_axi_awready_out,
  input wire logic              s_axi_wvalid_in,
  input wire logic              s_axi_wready_out,
  input wire logic              s_axi_bvalid_out,
  input wire logic [1:0]        s_axi_bresp_out,
  input wire logic              s_axi_bready_in,
  input wire logic              s_axi_arvalid_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic              s_axi_arready_out,
  input wire logic              s_axi_rvalid_out,
  input wire logic [31:0]       s_axi_rdata_out,
  input wire logic [1:0]        s_axi_rresp_out,
  input wire logic              s_axi_rready_in,
  input wire logic              fault_in,
  input wire logic              gen0_irq_in,
  input wire logic              gen1_irq_in,
  input wire logic              intr_out
);
  logic [ADDR_W-1:0] ra_reg;
  logic              fs_reg;
  logic              unmap;
  // over-approximates the latch: never cleared except by reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ra_reg <= '0;
      fs_reg <= 1'b0;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) ra_reg <= s_axi_araddr_in;
      if (fault_in) fs_reg <= 1'b1;
    end
  end
  assign unmap = ra_reg[ADDR_W-1:2] != OFF_ENABLE[ADDR_W-1:2] &&
                 ra_reg[ADDR_W-1:2] != OFF_RAW[ADDR_W-1:2] &&
                 ra_reg[ADDR_W-1:2] != OFF_ISC[ADDR_W-1:2];
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("bresp dropped before bready");
  chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before rready");
  chk_b_lat: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out
    |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  chk_r_lat: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read answer late");
  chk_rd_unmap: assert property (s_axi_rvalid_out && unmap
    |-> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == '0)
    else $error("unmapped read not refused");
  chk_rd_resvd: assert property (
    s_axi_rvalid_out && !unmap |-> s_axi_rresp_out == RESP_OKAY &&
    s_axi_rdata_out[31:17] == '0 && s_axi_rdata_out[15:2] == '0)
    else $error("reserved bits not zero");
  chk_intr_cause: assert property ($rose(intr_out) |->
    $past(gen0_irq_in || gen1_irq_in, 2) || fs_reg)
    else $error("interrupt without source");
  chk_intr_quiet: assert property (
    (!gen0_irq_in && !gen1_irq_in && !fs_reg) [*3] |-> !intr_out)
    else $error("interrupt with sources idle");
endmodule : pig_checker
bind pig_top pig_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk_in,
  .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bresp_out,
  .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_araddr_in,
  .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_rready_in, .fault_in, .gen0_irq_in,
  .gen1_irq_in, .intr_out);
`default_nettype wire

// File: test/pig_irq_sink.sv
`timescale 1ns/1ps
`default_nettype none
// interrupt controller side: registers the level one clock later
module pig_irq_sink (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic intr_in,
  output var  logic pend_out
);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) pend_out <= 1'b0;
    else pend_out <= intr_in;
  end
endmodule : pig_irq_sink
`default_nettype wire

// File: test/tb_pwm_module_interrupt_gating.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module tb_pwm_module_interrupt_gating;
  import pig_pkg::*;
  localparam logic [11:0] AE = OFF_ENABLE[11:0];
  localparam logic [11:0] AR = OFF_RAW[11:0];
  localparam logic [11:0] AC = OFF_ISC[11:0];
  logic        clk, rst_n, awv, wv, bry, arv, rry, flt, fclr;
  logic [1:0]  gen;
  logic [11:0] awa, ara;
  logic [31:0] wd;
  wire logic   awr, wrdy, bv, arr, rv, intr, pend;
  wire logic [1:0]  brsp, rrsp;
  wire logic [31:0] rdat;
  int          n_mismatch, cmp_count;
  pig_top #(.ADDR_W(12)) dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa),
    .s_axi_awready_out(awr), .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wready_out(wrdy),
    .s_axi_bvalid_out(bv), .s_axi_bresp_out(brsp),
    .s_axi_bready_in(bry), .s_axi_arvalid_in(arv),
    .s_axi_araddr_in(ara), .s_axi_arready_out(arr),
    .s_axi_rvalid_out(rv), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rrsp), .s_axi_rready_in(rry), .fault_in(flt),
    .gen0_irq_in(gen[0]), .gen1_irq_in(gen[1]), .fault_clr_in(fclr),
    .intr_out(intr));
  pig_irq_sink u_sink (.core_clk_in(clk), .rst_n_in(rst_n),
    .intr_in(intr), .pend_out(pend));
  task automatic report_and_stop;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic tmo(input int n);
    if (n >= 40) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask : tmo
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic wc(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic ad = 1'b0;
    logic dd = 1'b0;
    int   n = 0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= v;
    while (!(ad && dd) && n < 40) begin
      @(posedge clk);
      n++;
      if (awr && !ad) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wrdy && !dd) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    while (!bv && n < 40) begin
      @(posedge clk);
      n++;
    end
    // bready raised late on purpose to stall the answer
    bry <= 1'b1;
    @(posedge clk);
    `CHK(brsp, er)
    bry <= 1'b0;
    tmo(n);
  endtask : wc
  task automatic rc(input logic [11:0] a, input logic [31:0] ev,
                    input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    do begin
      @(posedge clk);
      n++;
    end while (!arr && n < 40);
    arv <= 1'b0;
    while (!rv && n < 40) begin
      @(posedge clk);
      n++;
    end
    rry <= 1'b1;
    @(posedge clk);
    `CHK(rdat, ev)
    `CHK(rrsp, er)
    rry <= 1'b0;
    tmo(n);
  endtask : rc
  task automatic t_bus;
    rc(AE, 32'h0, RESP_OKAY);
    rc(AR, 32'h0, RESP_OKAY);
    wc(12'h100, 32'h3, RESP_SLVERR);
    rc(12'h100, 32'h0, RESP_SLVERR);
    wc(AR, 32'h3, RESP_OKAY);
    rc(AR, 32'h0, RESP_OKAY);
    wc(AE, 32'h0001_0003, RESP_OKAY);
    rc(AE, 32'h0001_0003, RESP_OKAY);
  endtask : t_bus
  task automatic t_gen;
    for (int i = 0; i < 2; i++) begin
      wc(AE, 32'h1 << i, RESP_OKAY);
      gen[i] <= 1'b1;
      cyc(4);
      `CHK(pend, 1'b1)
      rc(AR, 32'h1 << i, RESP_OKAY);
      wc(AE, 32'h2 >> i, RESP_OKAY);
      cyc(2);
      `CHK(intr, 1'b0)
      gen[i] <= 1'b0;
      cyc(2);
      rc(AR, 32'h0, RESP_OKAY);
    end
  endtask : t_gen
  task automatic t_fault;
    wc(AE, 32'h0001_0000, RESP_OKAY);
    flt <= 1'b1;
    cyc(1);
    flt <= 1'b0;
    cyc(3);
    `CHK(intr, 1'b1)
    rc(AR, 32'h0001_0000, RESP_OKAY);
    wc(AC, 32'h0, RESP_OKAY);
    rc(AR, 32'h0001_0000, RESP_OKAY);
    wc(AC, 32'h0001_0000, RESP_OKAY);
    rc(AR, 32'h0, RESP_OKAY);
    cyc(2);
    `CHK(intr, 1'b0)
    gen <= 2'h3;
    flt <= 1'b1;
    wc(AE, 32'h0, RESP_OKAY);
    flt <= 1'b0;
    rc(AR, 32'h0001_0003, RESP_OKAY);
    `CHK(intr, 1'b0)
    wc(AE, 32'h0001_0003, RESP_OKAY);
    cyc(2);
    `CHK(intr, 1'b1)
    gen <= 2'h0;
    fclr <= 1'b1;
    cyc(1);
    fclr <= 1'b0;
    rc(AR, 32'h0, RESP_OKAY);
  endtask : t_fault
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_n, awv, wv, bry, arv, rry, flt, fclr} = '0;
    gen = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_bus;
    t_gen;
    t_fault;
    report_and_stop;
  end
endmodule : tb_pwm_module_interrupt_gating
`default_nettype wire
